// [rtl/macpt_pkg.sv]
package macpt_pkg;

  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int AXIS_W = 32;
  localparam int ADDR_W = 8;
  localparam int NUM_PR = 64;
  localparam int PR_IDX_W = 6;
  localparam int NUM_PROF = 16;
  localparam int PROF_IDX_W = 4;
  localparam int PROF_W = 16;
  localparam int NUM_EVENTS = 4;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIME_TICK_NS = 1000000;
  localparam int TIME_TICK_CYCLES = TIME_TICK_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MOTOR_FEEDBACK_AXIS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AUX_SCALE_AXIS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HOST_PULSE_AXIS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LATCH_AXIS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MATCH_AXIS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAM_MASTER_AXIS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SYNC_LATCH_AXIS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SYNC_LATCH_OFFSET = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PR_COMMAND_AXIS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TIME_AXIS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_VALUE = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_PR_INDEX = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_PR_DATA = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_PROF_INDEX = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_ACCEL_TIME = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_SPEED = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_DELAY_TIME = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MAP = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_SOFTWARE_PROGRAM_TRIGGER = 8'h50;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int STAT_CAPTURE_DONE = 0;
  localparam int STAT_FIRST_CAPTURED = 1;
  localparam int STAT_CAPTURE_ODD = 2;
  localparam int EVMAP_CAPTURE_POS = 24;
  localparam logic [AXIS_W-1:0] RST_AXIS = 32'h0000_0000;
  localparam logic [31:0] RST_EVENT_MAP = 32'h0000_0000;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_PULSE_DIR = 2'b00,
    FMT_CW_CCW = 2'b01,
    FMT_QUADRATURE = 2'b10
  } macpt_fmt_t;

  typedef enum logic [1:0] {
    JOIN_SEQUENTIAL = 2'b00,
    JOIN_INSERTION = 2'b01,
    JOIN_OVERLAP = 2'b10
  } macpt_join_t;

  // source codes: latch 0 motor 1 aux 2 host; match adds 3 latch;
  // cam master 0 aux 1 host 2 latch 3 pr command
  localparam logic [1:0] SRC_0 = 2'b00;
  localparam logic [1:0] SRC_1 = 2'b01;
  localparam logic [1:0] SRC_2 = 2'b10;
  localparam logic [1:0] SRC_3 = 2'b11;

  typedef struct packed {
    logic [1:0] join_mode;
    logic [1:0] cam_src;
    logic [1:0] match_src;
    logic [1:0] latch_src;
    logic [1:0] pulse_format_select;
  } macpt_cfg_t;

  localparam macpt_cfg_t RST_CFG = 10'h000;

  typedef struct packed {
    logic mot_a;
    logic mot_b;
    logic aux_a;
    logic aux_b;
    logic pls_a;
    logic pls_b;
    logic capture_in;
    logic program_trigger_strobe;
    logic [PR_IDX_W-1:0] program_index_inputs;
    logic [NUM_EVENTS-1:0] event_trigger_inputs;
  } macpt_pins_t;

  typedef struct packed {
    logic start;
    logic [PR_IDX_W-1:0] index;
    logic [1:0] join_mode;
    logic [AXIS_W-1:0] position;
  } macpt_trig_t;

endpackage

// [rtl/macpt_top.sv]
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - every motion axis is a signed 32-bit absolute position counter
// - motor feedback axis counts the motor encoder and is read-only
// - aux scale axis counts A/B quadrature only; scale must supply quadrature; RW
// - host pulse axis counts host pulses, format configurable, RW
// - latch axis follows motor, aux or host axis with an offset
// - latch axis accepts a written value once the first capture happened
// - match axis follows motor, aux, host or latch axis with an offset
// - cam master follows aux, host, latch or pr command axis with offset
// - time axis is read-only, counts one per millisecond
// - sync latch axis acts like latch axis, corrects offset every second capture
// - output axes step by exactly the source increment
// - physical axes count only the actual input pins
// - virtual axes only selectable as cam master source
// - strobe starts a program; controller holds six index inputs stable
// - sixty-four position registers, each a program entry point
// - programs also start from four events, capture done, software trigger
// - triggers accepted anytime, joined sequential, insertion or overlap
// - position registers hold 32-bit user-unit values
// - sixteen accel/decel times, speeds and delay times
module macpt_top
  import macpt_pkg::*;
#(
  parameter int TICK_CYCLES = TIME_TICK_CYCLES,
  parameter int PROF_WIDTH = PROF_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // encoder and pulse pins
  input wire logic mot_a,
  input wire logic mot_b,
  input wire logic aux_a,
  input wire logic aux_b,
  input wire logic pls_a,
  input wire logic pls_b,
  input wire logic capture_in,
  // program trigger pins
  input wire logic program_trigger_strobe,
  input wire logic [PR_IDX_W-1:0] program_index_inputs,
  input wire logic [NUM_EVENTS-1:0] event_trigger_inputs,
  // program start towards the motion engine
  output macpt_trig_t trig,
  output logic capture_done
);

  if (TICK_CYCLES < 2 || PROF_WIDTH < 1 || PROF_WIDTH > 32)
  begin : g_check
    $error("macpt_top: unsupported parameter value");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // forward is 00 -> 01 -> 11 -> 10 on {a,b}; illegal double jumps count 0
  function automatic logic signed [AXIS_W-1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    case ({p, c})
      4'h1, 4'h7, 4'he, 4'h8: quad_step = 32'sh0000_0001;
      4'h2, 4'hb, 4'hd, 4'h4: quad_step = -32'sh0000_0001;
      default: quad_step = 32'sh0000_0000;
    endcase
  endfunction

  function automatic logic signed [AXIS_W-1:0] host_step(input logic [1:0] fmt, input logic [1:0] p,
                                                         input logic [1:0] c);
    logic rise_a;
    logic rise_b;
    rise_a = c[1] & ~p[1];
    rise_b = c[0] & ~p[0];
    host_step = 32'sh0000_0000;
    case (fmt)
      FMT_PULSE_DIR:
      begin
        if (rise_a)
          host_step = c[0] ? -32'sh0000_0001 : 32'sh0000_0001;
      end
      FMT_CW_CCW:
      begin
        if (rise_a && !rise_b)
          host_step = 32'sh0000_0001;
        else if (rise_b && !rise_a)
          host_step = -32'sh0000_0001;
      end
      FMT_QUADRATURE: host_step = quad_step(p, c);
      default: host_step = 32'sh0000_0000;
    endcase
  endfunction

  function automatic logic signed [AXIS_W-1:0] pick(input logic [1:0] sel, input logic signed [AXIS_W-1:0] d0,
                                                    input logic signed [AXIS_W-1:0] d1,
                                                    input logic signed [AXIS_W-1:0] d2,
                                                    input logic signed [AXIS_W-1:0] d3);
    case (sel)
      SRC_0: pick = d0;
      SRC_1: pick = d1;
      SRC_2: pick = d2;
      default: pick = d3;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  macpt_pins_t pins_raw;
  macpt_pins_t pins_s1;
  macpt_pins_t pins_s2;
  macpt_pins_t pins_prev;

  assign pins_raw = '{mot_a: mot_a, mot_b: mot_b, aux_a: aux_a, aux_b: aux_b, pls_a: pls_a, pls_b: pls_b,
                      capture_in: capture_in, program_trigger_strobe: program_trigger_strobe,
                      program_index_inputs: program_index_inputs, event_trigger_inputs: event_trigger_inputs};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      pins_prev <= '0;
    end
    else
    begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      pins_prev <= pins_s2;
    end
  end

  // ---------------------------------------------------------------
  // axis counters
  // ---------------------------------------------------------------
  logic signed [AXIS_W-1:0] motor_feedback_axis, next_motor_feedback_axis;
  logic signed [AXIS_W-1:0] aux_scale_axis, next_aux_scale_axis;
  logic signed [AXIS_W-1:0] host_pulse_axis, next_host_pulse_axis;
  logic signed [AXIS_W-1:0] latch_axis, next_latch_axis;
  logic signed [AXIS_W-1:0] match_axis, next_match_axis;
  logic signed [AXIS_W-1:0] cam_master_axis, next_cam_master_axis;
  logic signed [AXIS_W-1:0] sync_latch_axis, next_sync_latch_axis;
  logic signed [AXIS_W-1:0] sync_latch_offset, next_sync_latch_offset;
  logic signed [AXIS_W-1:0] pr_command_axis, next_pr_command_axis;
  logic [AXIS_W-1:0] time_axis, next_time_axis;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [AXIS_W-1:0] capture_value, next_capture_value;
  logic first_captured, next_first_captured;
  logic capture_odd, next_capture_odd;
  logic next_capture_done;
  macpt_cfg_t cfg, next_cfg;

  logic signed [AXIS_W-1:0] d_mot, d_aux, d_host, d_latch, d_match, d_cam, d_pr;
  logic capture_evt;

  always_comb
  begin
    d_mot = quad_step({pins_prev.mot_a, pins_prev.mot_b}, {pins_s2.mot_a, pins_s2.mot_b});
    d_aux = quad_step({pins_prev.aux_a, pins_prev.aux_b}, {pins_s2.aux_a, pins_s2.aux_b});
    d_host = host_step(cfg.pulse_format_select, {pins_prev.pls_a, pins_prev.pls_b},
                       {pins_s2.pls_a, pins_s2.pls_b});
    d_pr = (wr && addr == OFS_PR_COMMAND_AXIS) ? $signed(wdata) - pr_command_axis : 32'sh0000_0000;
    // virtual axes feed no latch or match source
    d_latch = pick(cfg.latch_src, d_mot, d_aux, d_host, 32'sh0000_0000);
    d_match = pick(cfg.match_src, d_mot, d_aux, d_host, d_latch);
    d_cam = pick(cfg.cam_src, d_aux, d_host, d_latch, d_pr);
    capture_evt = pins_s2.capture_in & ~pins_prev.capture_in;

    // plain adds wrap at 32 bits rather than saturate
    next_motor_feedback_axis = motor_feedback_axis + d_mot;
    next_aux_scale_axis = aux_scale_axis + d_aux;
    next_host_pulse_axis = host_pulse_axis + d_host;
    next_latch_axis = latch_axis + d_latch;
    next_match_axis = match_axis + d_match;
    next_cam_master_axis = cam_master_axis + d_cam;
    next_sync_latch_axis = sync_latch_axis + d_latch;
    next_sync_latch_offset = sync_latch_offset;
    next_pr_command_axis = pr_command_axis;
    next_cfg = cfg;
    next_capture_value = capture_value;
    next_first_captured = first_captured;
    next_capture_odd = capture_odd;
    next_capture_done = capture_done;

    if (tick_cnt == 32'(TICK_CYCLES - 1))
    begin
      next_tick_cnt = '0;
      next_time_axis = time_axis + 32'h0000_0001;
    end
    else
    begin
      next_tick_cnt = tick_cnt + 32'h0000_0001;
      next_time_axis = time_axis;
    end

    // a written value replaces that cycle's count step
    if (wr)
    begin
      case (addr)
        OFS_AUX_SCALE_AXIS: next_aux_scale_axis = $signed(wdata);
        OFS_HOST_PULSE_AXIS: next_host_pulse_axis = $signed(wdata);
        OFS_LATCH_AXIS:
        begin
          if (first_captured)
            next_latch_axis = $signed(wdata);
        end
        OFS_MATCH_AXIS: next_match_axis = $signed(wdata);
        OFS_CAM_MASTER_AXIS: next_cam_master_axis = $signed(wdata);
        OFS_SYNC_LATCH_AXIS: next_sync_latch_axis = $signed(wdata);
        OFS_SYNC_LATCH_OFFSET: next_sync_latch_offset = $signed(wdata);
        OFS_PR_COMMAND_AXIS: next_pr_command_axis = $signed(wdata);
        OFS_CONFIG: next_cfg = wdata[9:0];
        OFS_STATUS:
        begin
          if (wdata[STAT_CAPTURE_DONE])
            next_capture_done = 1'b0;
        end
        default: ;
      endcase
    end

    // capture after the clear so a same-cycle event is kept
    if (capture_evt)
    begin
      next_capture_value = latch_axis;
      next_first_captured = 1'b1;
      next_capture_done = 1'b1;
      next_capture_odd = ~capture_odd;
      if (capture_odd)
        next_sync_latch_axis = next_sync_latch_axis + sync_latch_offset;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      motor_feedback_axis <= RST_AXIS;
      aux_scale_axis <= RST_AXIS;
      host_pulse_axis <= RST_AXIS;
      latch_axis <= RST_AXIS;
      match_axis <= RST_AXIS;
      cam_master_axis <= RST_AXIS;
      sync_latch_axis <= RST_AXIS;
      sync_latch_offset <= RST_AXIS;
      pr_command_axis <= RST_AXIS;
      time_axis <= RST_AXIS;
      tick_cnt <= '0;
      capture_value <= RST_AXIS;
      first_captured <= 1'b0;
      capture_odd <= 1'b0;
      capture_done <= 1'b0;
      cfg <= RST_CFG;
    end
    else
    begin
      motor_feedback_axis <= next_motor_feedback_axis;
      aux_scale_axis <= next_aux_scale_axis;
      host_pulse_axis <= next_host_pulse_axis;
      latch_axis <= next_latch_axis;
      match_axis <= next_match_axis;
      cam_master_axis <= next_cam_master_axis;
      sync_latch_axis <= next_sync_latch_axis;
      sync_latch_offset <= next_sync_latch_offset;
      pr_command_axis <= next_pr_command_axis;
      time_axis <= next_time_axis;
      tick_cnt <= next_tick_cnt;
      capture_value <= next_capture_value;
      first_captured <= next_first_captured;
      capture_odd <= next_capture_odd;
      capture_done <= next_capture_done;
      cfg <= next_cfg;
    end
  end

  // ---------------------------------------------------------------
  // position registers and motion tables
  // ---------------------------------------------------------------
  logic [AXIS_W-1:0] pr_mem [NUM_PR];
  logic [PROF_WIDTH-1:0] accel_mem [NUM_PROF];
  logic [PROF_WIDTH-1:0] speed_mem [NUM_PROF];
  logic [PROF_WIDTH-1:0] delay_mem [NUM_PROF];
  logic [PR_IDX_W-1:0] pr_index, next_pr_index;
  logic [PROF_IDX_W-1:0] prof_index, next_prof_index;
  logic [31:0] event_map, next_event_map;
  logic pr_we, accel_we, speed_we, delay_we;

  always_comb
  begin
    next_pr_index = pr_index;
    next_prof_index = prof_index;
    next_event_map = event_map;
    pr_we = wr && addr == OFS_PR_DATA;
    accel_we = wr && addr == OFS_ACCEL_TIME;
    speed_we = wr && addr == OFS_SPEED;
    delay_we = wr && addr == OFS_DELAY_TIME;
    if (wr && addr == OFS_PR_INDEX)
      next_pr_index = wdata[PR_IDX_W-1:0];
    if (wr && addr == OFS_PROF_INDEX)
      next_prof_index = wdata[PROF_IDX_W-1:0];
    if (wr && addr == OFS_EVENT_MAP)
      next_event_map = wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pr_index <= '0;
      prof_index <= '0;
      event_map <= RST_EVENT_MAP;
    end
    else
    begin
      pr_index <= next_pr_index;
      prof_index <= next_prof_index;
      event_map <= next_event_map;
    end
  end

  // tables carry no reset: contents are defined only once software loads them
  always_ff @(posedge clk)
  begin
    if (pr_we)
      pr_mem[pr_index] <= wdata;
    if (accel_we)
      accel_mem[prof_index] <= wdata[PROF_WIDTH-1:0];
    if (speed_we)
      speed_mem[prof_index] <= wdata[PROF_WIDTH-1:0];
    if (delay_we)
      delay_mem[prof_index] <= wdata[PROF_WIDTH-1:0];
  end

  // ---------------------------------------------------------------
  // program trigger
  // ---------------------------------------------------------------
  // pending bits: 0 strobe, 1..4 events, 5 capture done, 6 software
  logic [6:0] pending, next_pending;
  logic [PR_IDX_W-1:0] strobe_idx, next_strobe_idx;
  logic [PR_IDX_W-1:0] sw_idx, next_sw_idx;
  macpt_trig_t next_trig;
  logic [6:0] arrive;
  logic [2:0] serve;
  logic [PR_IDX_W-1:0] serve_idx;

  always_comb
  begin
    arrive[0] = pins_s2.program_trigger_strobe & ~pins_prev.program_trigger_strobe;
    arrive[4:1] = pins_s2.event_trigger_inputs & ~pins_prev.event_trigger_inputs;
    arrive[5] = capture_evt;
    arrive[6] = wr && addr == OFS_SOFTWARE_PROGRAM_TRIGGER;
    next_strobe_idx = arrive[0] ? pins_s2.program_index_inputs : strobe_idx;
    next_sw_idx = arrive[6] ? wdata[PR_IDX_W-1:0] : sw_idx;
    serve = 3'h7;
    for (int i = 6; i >= 0; i--)
    begin
      if (pending[i])
        serve = 3'(i);
    end
    case (serve)
      3'h0: serve_idx = strobe_idx;
      3'h1: serve_idx = event_map[5:0];
      3'h2: serve_idx = event_map[11:6];
      3'h3: serve_idx = event_map[17:12];
      3'h4: serve_idx = event_map[23:18];
      3'h5: serve_idx = event_map[EVMAP_CAPTURE_POS +: PR_IDX_W];
      default: serve_idx = sw_idx;
    endcase
    // no busy check: a trigger issues even while motion runs
    next_pending = pending;
    next_trig = '0;
    if (serve != 3'h7)
    begin
      next_pending[serve] = 1'b0;
      next_trig.start = 1'b1;
      next_trig.index = serve_idx;
      next_trig.join_mode = cfg.join_mode;
      next_trig.position = pr_mem[serve_idx];
    end
    // a new arrival wins over the clear of the one being served
    next_pending = next_pending | arrive;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pending <= '0;
      strobe_idx <= '0;
      sw_idx <= '0;
      trig <= '0;
    end
    else
    begin
      pending <= next_pending;
      strobe_idx <= next_strobe_idx;
      sw_idx <= next_sw_idx;
      trig <= next_trig;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        OFS_MOTOR_FEEDBACK_AXIS: next_rdata = motor_feedback_axis;
        OFS_AUX_SCALE_AXIS: next_rdata = aux_scale_axis;
        OFS_HOST_PULSE_AXIS: next_rdata = host_pulse_axis;
        OFS_LATCH_AXIS: next_rdata = latch_axis;
        OFS_MATCH_AXIS: next_rdata = match_axis;
        OFS_CAM_MASTER_AXIS: next_rdata = cam_master_axis;
        OFS_SYNC_LATCH_AXIS: next_rdata = sync_latch_axis;
        OFS_SYNC_LATCH_OFFSET: next_rdata = sync_latch_offset;
        OFS_PR_COMMAND_AXIS: next_rdata = pr_command_axis;
        OFS_TIME_AXIS: next_rdata = time_axis;
        OFS_CONFIG: next_rdata = {22'h00_0000, cfg};
        OFS_STATUS: next_rdata = {29'h0000_0000, capture_odd, first_captured, capture_done};
        OFS_CAPTURE_VALUE: next_rdata = capture_value;
        OFS_PR_INDEX: next_rdata = {26'h000_0000, pr_index};
        OFS_PR_DATA: next_rdata = pr_mem[pr_index];
        OFS_PROF_INDEX: next_rdata = {28'h000_0000, prof_index};
        OFS_ACCEL_TIME: next_rdata = 32'(accel_mem[prof_index]);
        OFS_SPEED: next_rdata = 32'(speed_mem[prof_index]);
        OFS_DELAY_TIME: next_rdata = 32'(delay_mem[prof_index]);
        OFS_EVENT_MAP: next_rdata = event_map;
        OFS_SOFTWARE_PROGRAM_TRIGGER: next_rdata = {26'h000_0000, sw_idx};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end

endmodule

// [sim/macpt_sva.sv]
`timescale 1ns/1ps
// ----
// port checks
// ----
module macpt_sva
  import macpt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // pins and results
  input wire logic capture_in,
  input wire logic program_trigger_strobe,
  input wire logic [PR_IDX_W-1:0] program_index_inputs,
  input wire macpt_trig_t trig,
  input wire logic capture_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata outside slot");
  property p_rst; $rose(rst_n) |-> trig == '0 && rdata == 32'h0 && !capture_done; endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  property p_sw; wr && addr == 8'h50 |-> ##[1:2] trig.start && trig.index == wdata[5:0]; endproperty
  a_sw: assert property (p_sw) else $error("software start");
  property p_stb;
    $past(program_trigger_strobe, 3) && !$past(program_trigger_strobe, 4)
      |-> ##[0:1] trig.start && trig.index == program_index_inputs;
  endproperty
  a_stb: assert property (p_stb) else $error("strobe start");
  property p_cap; $rose(capture_done) |-> $past(capture_in, 3) && !$past(capture_in, 4); endproperty
  a_cap: assert property (p_cap) else $error("capture timing");
  property p_cap_trig; $rose(capture_done) |-> ##[0:1] trig.start; endproperty
  a_cap_trig: assert property (p_cap_trig) else $error("capture start");
  property p_clr;
    wr && addr == 8'h2c && wdata[0] && $past(capture_in, 2) == $past(capture_in, 3) |=> !capture_done;
  endproperty
  a_clr: assert property (p_clr) else $error("capture clear");
  property p_keep; capture_done && !(wr && addr == 8'h2c) |=> capture_done; endproperty
  a_keep: assert property (p_keep) else $error("capture lost");
endmodule

bind macpt_top macpt_sva i_sva (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .capture_in(capture_in), .program_trigger_strobe(program_trigger_strobe),
  .program_index_inputs(program_index_inputs), .trig(trig), .capture_done(capture_done));

// [sim/macpt_enc.sv]
`timescale 1ns/1ps
// ----
// quadrature encoder model
// ----
module macpt_enc (
  // bench side
  input wire logic clk,
  input wire logic step,
  input wire logic back,
  // pins
  output logic a,
  output logic b
);
  logic [1:0] ph = 2'b00;
  // one gray step per request, never a double jump
  always @(posedge clk)
    if (step)
      ph <= back ? {~ph[0], ph[1]} : {ph[0], ~ph[1]};
  assign {a, b} = ph;
endmodule

// [sim/macpt_bench.sv]
`timescale 1ns/1ps
// ----
// bench
// ----
module macpt_bench;
  import macpt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] rdata;
  logic [2:0] st = '0;
  logic bk = 1'b0;
  logic [2:0] pa;
  logic [2:0] pb;
  logic cap = 1'b0;
  logic stb = 1'b0;
  logic [5:0] idx = '0;
  logic [3:0] ev = '0;
  macpt_trig_t trig;
  logic cdone;
  logic [31:0] rq[$];
  logic [39:0] tq[$];
  logic [31:0] v[8];
  logic [31:0] pr[64];
  int dl[8] = '{3, 2, -3, 3, 3, 2, 3, 0};
  int fails = 0;
  int n_checks = 0;
  int seed = 32'hcfd91553;
  int cyc = 0;
  localparam int TICKS = 10;
  always #2 clk = ~clk;
  macpt_top #(.TICK_CYCLES(TICKS)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .mot_a(pa[0]), .mot_b(pb[0]), .aux_a(pa[1]), .aux_b(pb[1]), .pls_a(pa[2]), .pls_b(pb[2]),
    .capture_in(cap), .program_trigger_strobe(stb), .program_index_inputs(idx), .event_trigger_inputs(ev),
    .trig(trig), .capture_done(cdone));
  macpt_enc i_enc[2:0] (.clk(clk), .step(st), .back(bk), .a(pa), .b(pb));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_t(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // pin edges spaced three cycles, above the two the synchroniser needs
  task automatic step_t(input int k, input int n, input logic b);
    repeat (n)
    begin
      st[k] <= 1'b1;
      bk <= b;
      @(posedge clk);
      st[k] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic trg_t(input int kind, input logic [5:0] i, input logic [1:0] j);
    idx <= i;
    wr_t(8'h28, {22'h0, j, 8'h2});
    wr_t(8'h4c, {8'h2a, 18'h0, i});
    tq.push_back({i, j, pr[i]});
    stb <= (kind == 0);
    ev[0] <= (kind == 1);
    if (kind == 2)
      wr_t(8'h50, {26'h0, i});
    repeat (8) @(posedge clk);
    stb <= 1'b0;
    ev <= '0;
    repeat (8) @(posedge clk);
  endtask
  task automatic cap_t();
    cap <= 1'b1;
    tq.push_back({6'h2a, 2'h2, pr[6'h2a]});
    repeat (8) @(posedge clk);
    cap <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    rd_q <= rd;
    if (rst_n)
      cyc <= cyc + 1;
    if (rd_q)
      chk(rdata, rq.size() ? rq.pop_front() : 32'hdead_beef);
    if (trig.start === 1'b1)
      chk(trig[39:0], tq.size() ? tq.pop_front() : '1);
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 'h30; a += 4)
      if (a != 'h24)
        rd_t(8'(a), 32'h0);
    rd_t(8'h80, 32'h0);
    $display("test reset done");
    v[1] = 32'hffff_ffff;
    for (int k = 2; k < 8; k++)
      v[k] = $random(seed);
    for (int k = 1; k < 8; k++)
      wr_t(8'(4 * k), v[k]);
    wr_t(8'h00, v[2]);
    v[0] = '0;
    v[3] = '0;
    for (int k = 0; k < 8; k++)
      rd_t(8'(4 * k), v[k]);
    wr_t(8'h3c, 32'hf);
    for (int k = 0; k < 3; k++)
      wr_t(8'(8'h40 + 4 * k), v[k + 4]);
    for (int k = 0; k < 3; k++)
      rd_t(8'(8'h40 + 4 * k), {16'h0, v[k + 4][15:0]});
    $display("test registers done");
    wr_t(8'h28, 32'h2);
    step_t(0, 5, 1'b0);
    step_t(0, 2, 1'b1);
    step_t(1, 2, 1'b0);
    step_t(2, 3, 1'b1);
    for (int k = 0; k < 8; k++)
      rd_t(8'(4 * k), v[k] + 32'(dl[k]));
    // one tick per TICKS edges out of reset; the read edge is one past this one
    rd_t(8'h24, 32'((cyc + 1) / TICKS));
    // host pins rest at 01: pulse/dir sees one rise of A with B high
    wr_t(8'h28, 32'h0);
    step_t(2, 4, 1'b0);
    rd_t(8'h08, v[2] - 32'h4);
    wr_t(8'h28, 32'h1);
    step_t(2, 2, 1'b0);
    rd_t(8'h08, v[2] - 32'h3);
    $display("test counting done");
    for (int k = 0; k < 64; k += 21)
    begin
      pr[k] = $random(seed);
      wr_t(8'h34, 32'(k));
      wr_t(8'h38, pr[k]);
    end
    rd_t(8'h38, pr[6'h3f]);
    trg_t(0, 6'h3f, 2'h0);
    trg_t(1, 6'h15, 2'h1);
    trg_t(2, 6'h00, 2'h2);
    $display("test triggers done");
    cap_t();
    chk(cdone, 1'b1);
    rd_t(8'h2c, 32'h7);
    rd_t(8'h30, 32'h3);
    wr_t(8'h0c, v[5]);
    rd_t(8'h0c, v[5]);
    wr_t(8'h2c, 32'h1);
    chk(cdone, 1'b0);
    cap_t();
    rd_t(8'h2c, 32'h3);
    rd_t(8'h18, v[6] + v[7] + 32'h3);
    $display("test capture done");
    repeat (20) @(posedge clk);
    if (rq.size() + tq.size() != 0)
      fails++;
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
endmodule
